// ### core/cpf_pkg.sv
// Constants shared by the cell protection state machine and its delay timers.
// Assumes a single 250 MHz clock and comparator results arriving from analog pins.
package cpf_pkg;

	// ------------------------------------------------------------------
	// Clock and delay times
	// ------------------------------------------------------------------
	localparam real CLK_FREQ_HZ     = 250.0e6;
	localparam real OV_DELAY_S      = 1.0;
	localparam real OVR_DELAY_MS    = 16.0;
	localparam real UV_DELAY_MS     = 128.0;
	localparam real UVR_DELAY_MS    = 1.1;
	localparam real DOC_DELAY_MS    = 12.0;
	localparam real DOCR_DELAY_MS   = 4.0;
	localparam real SC_DELAY_US     = 200.0;
	localparam real COC_DELAY_MS    = 16.0;

	localparam int unsigned OV_CYCLES   = int'($floor(OV_DELAY_S * CLK_FREQ_HZ));
	localparam int unsigned OVR_CYCLES  = int'($floor(OVR_DELAY_MS * 1.0e-3 * CLK_FREQ_HZ));
	localparam int unsigned UV_CYCLES   = int'($floor(UV_DELAY_MS * 1.0e-3 * CLK_FREQ_HZ));
	localparam int unsigned UVR_CYCLES  = int'($floor(UVR_DELAY_MS * 1.0e-3 * CLK_FREQ_HZ));
	localparam int unsigned DOC_CYCLES  = int'($floor(DOC_DELAY_MS * 1.0e-3 * CLK_FREQ_HZ));
	localparam int unsigned DOCR_CYCLES = int'($floor(DOCR_DELAY_MS * 1.0e-3 * CLK_FREQ_HZ));
	localparam int unsigned SC_CYCLES   = int'($floor(SC_DELAY_US * 1.0e-6 * CLK_FREQ_HZ));
	localparam int unsigned COC_CYCLES  = int'($floor(COC_DELAY_MS * 1.0e-3 * CLK_FREQ_HZ));

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
	localparam int          CTRL_FORCE_BIT  = 0;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam int          STAT_STATE_LSB  = 0;
	localparam int          STAT_CHG_BIT    = 4;
	localparam int          STAT_DCHG_BIT   = 5;
	localparam int          STAT_PDN_BIT    = 6;
	localparam int          STAT_PUP_BIT    = 7;
	localparam int          STAT_BIAS_BIT   = 8;
	localparam int          STAT_COCEN_BIT  = 9;

	// ------------------------------------------------------------------
	// Comparator input vector positions and timer indices
	// ------------------------------------------------------------------
	localparam int NUM_CMP   = 11;
	localparam int CMP_OV    = 0;
	localparam int CMP_OVR   = 1;
	localparam int CMP_UV    = 2;
	localparam int CMP_UVR   = 3;
	localparam int CMP_DOC   = 4;
	localparam int CMP_SC    = 5;
	localparam int CMP_REL   = 6;
	localparam int CMP_COC   = 7;
	localparam int CMP_CHGR  = 8;
	localparam int CMP_LOAD  = 9;
	localparam int CMP_ZERO  = 10;

	localparam int NUM_TMR   = 8;
	localparam int T_OV      = 0;
	localparam int T_OVR     = 1;
	localparam int T_UV      = 2;
	localparam int T_UVR     = 3;
	localparam int T_DOC     = 4;
	localparam int T_DOCR    = 5;
	localparam int T_SC      = 6;
	localparam int T_COC     = 7;

	typedef enum logic [3:0] {
		CPF_NORMAL,
		CPF_OVERCHARGE,
		CPF_OC_SHORT,
		CPF_OVERDISCHARGE,
		CPF_DISCH_OVERCURRENT,
		CPF_SHORT_CIRCUIT,
		CPF_CHG_OVERCURRENT
	} cpf_state_type;

endpackage

// ### core/cpf_delay_timer.sv
// Qualification timer: reports expiry once its condition has held for CYCLES clocks.
// Assumes the condition is already synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module cpf_delay_timer
	import cpf_pkg::*;
#(
	parameter int unsigned CYCLES = 32'd16
)
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic cond_i,
	output logic      expired_o
);

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	logic [31:0] count_reg;
	logic [31:0] count_next;

	if (CYCLES == 0)
	begin : g_bad
		$error("cpf_delay_timer needs CYCLES of at least one");
	end

	// A dropped condition restarts the count so that glitches never add up.
	always_comb
	begin
		if (!cond_i)
			count_next = 32'h0000_0000;
		else if (count_reg < CYCLES)
			count_next = count_reg + 32'h0000_0001;
		else
			count_next = count_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			count_reg <= 32'h0000_0000;
		else
			count_reg <= count_next;
	end

	assign expired_o = cond_i && (count_reg == CYCLES);

endmodule
`default_nettype wire

// ### core/cell_protection_fsm.sv
// Protection state machine for one lithium-ion cell driving charge and discharge switches.
// Assumes comparator results arrive asynchronously from analog pins, and a simple
// register port with read data one cycle after the read strobe.
//
// Summary of operation
// - Both switches on while voltage and current stay inside all thresholds.
// - Over-charge held for the over-charge delay turns charge switch off.
// - Leave over-charge on no charger, load current, and timed release voltage.
// - In over-charge only the short-circuit comparator guards discharge.
// - Over-charge short: discharge off, pull-down; recover to over-charge after load gone.
// - Over-discharge held 128 ms turns discharge switch off.
// - After over-discharge enable sense pull-up and shut bias off.
// - Charger re-biases; timed release voltage turns discharge on, back to normal.
// - Charge over-current detection disabled until voltage exceeds over-discharge release.
// - Discharge over-current held for its delay: discharge off, pull-down on.
// - Over-current or short recovers after load gone and timed sense release.
// - Short-circuit level held for its delay: discharge off, pull-down on.
// - Charge over-current held for its delay turns charge switch off.
// - Charge over-current recovers when charger removed; sense release not required.
// - Charge switch forced off while cell is below the zero-volt inhibit level.
// - Over-charge detection delay is 1.0 s.
// - Over-charge release and charge over-current delays are 16.0 ms.
// - Discharge over-current delay 12.0 ms; over-current release delay 4.0 ms.
// - Short-circuit delay 200 us; over-discharge release delay 1.1 ms.
`timescale 1ns/10ps
`default_nettype none
module cell_protection_fsm
	import cpf_pkg::*;
#(
	parameter int unsigned OV_CYC   = OV_CYCLES,
	parameter int unsigned OVR_CYC  = OVR_CYCLES,
	parameter int unsigned UV_CYC   = UV_CYCLES,
	parameter int unsigned UVR_CYC  = UVR_CYCLES,
	parameter int unsigned DOC_CYC  = DOC_CYCLES,
	parameter int unsigned DOCR_CYC = DOCR_CYCLES,
	parameter int unsigned SC_CYC   = SC_CYCLES,
	parameter int unsigned COC_CYC  = COC_CYCLES
)
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              overcharge_det_i,
	input  wire logic              below_overcharge_release_i,
	input  wire logic              overdischarge_det_i,
	input  wire logic              above_overdischarge_release_i,
	input  wire logic              discharge_overcurrent_det_i,
	input  wire logic              short_circuit_det_i,
	input  wire logic              sense_release_i,
	input  wire logic              charge_overcurrent_det_i,
	input  wire logic              charger_present_i,
	input  wire logic              load_present_i,
	input  wire logic              below_zero_volt_inhibit_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_write_i,
	input  wire logic              reg_read_i,
	output logic      [31:0]       reg_rdata_o,
	output logic                   charge_switch_o,
	output logic                   discharge_switch_o,
	output logic                   sense_pulldown_o,
	output logic                   sense_pullup_o,
	output logic                   bias_enable_o
);

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	logic [NUM_CMP-1:0] cmp_raw;
	logic [NUM_CMP-1:0] sync1_reg;
	logic [NUM_CMP-1:0] sync2_reg;

	assign cmp_raw[CMP_OV]   = overcharge_det_i;
	assign cmp_raw[CMP_OVR]  = below_overcharge_release_i;
	assign cmp_raw[CMP_UV]   = overdischarge_det_i;
	assign cmp_raw[CMP_UVR]  = above_overdischarge_release_i;
	assign cmp_raw[CMP_DOC]  = discharge_overcurrent_det_i;
	assign cmp_raw[CMP_SC]   = short_circuit_det_i;
	assign cmp_raw[CMP_REL]  = sense_release_i;
	assign cmp_raw[CMP_COC]  = charge_overcurrent_det_i;
	assign cmp_raw[CMP_CHGR] = charger_present_i;
	assign cmp_raw[CMP_LOAD] = load_present_i;
	assign cmp_raw[CMP_ZERO] = below_zero_volt_inhibit_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= cmp_raw;
			sync2_reg <= sync1_reg;
		end
	end

	// ------------------------------------------------------------------
	// State, flags and decode helpers
	// ------------------------------------------------------------------
	cpf_state_type state_reg;
	cpf_state_type state_next;
	logic          bias_reg;
	logic          bias_next;
	logic          coc_en_reg;
	logic          coc_en_next;
	logic          force_off_reg;
	logic          force_off_next;

	function automatic logic discharge_blocked(input cpf_state_type s);
		discharge_blocked = (s == CPF_OVERDISCHARGE) || (s == CPF_DISCH_OVERCURRENT) ||
			(s == CPF_SHORT_CIRCUIT) || (s == CPF_OC_SHORT);
	endfunction

	function automatic logic charge_blocked(input cpf_state_type s);
		charge_blocked = (s == CPF_OVERCHARGE) || (s == CPF_OC_SHORT) ||
			(s == CPF_CHG_OVERCURRENT);
	endfunction

	// ------------------------------------------------------------------
	// Delay timers
	// ------------------------------------------------------------------
	localparam int unsigned TMR_CYC [NUM_TMR] = '{OV_CYC, OVR_CYC, UV_CYC, UVR_CYC,
		DOC_CYC, DOCR_CYC, SC_CYC, COC_CYC};

	logic [NUM_TMR-1:0] tmr_cond;
	logic [NUM_TMR-1:0] tmr_exp;
	logic               in_normal;

	assign in_normal        = (state_reg == CPF_NORMAL);
	assign tmr_cond[T_OV]   = in_normal && sync2_reg[CMP_OV];
	assign tmr_cond[T_OVR]  = (state_reg == CPF_OVERCHARGE) && sync2_reg[CMP_OVR];
	assign tmr_cond[T_UV]   = in_normal && sync2_reg[CMP_UV];
	assign tmr_cond[T_UVR]  = (state_reg == CPF_OVERDISCHARGE) && bias_reg &&
		sync2_reg[CMP_UVR];
	// The ordinary over-current comparator is not timed in over-charge.
	assign tmr_cond[T_DOC]  = in_normal && sync2_reg[CMP_DOC];
	assign tmr_cond[T_DOCR] = ((state_reg == CPF_DISCH_OVERCURRENT) ||
		(state_reg == CPF_SHORT_CIRCUIT)) && sync2_reg[CMP_REL];
	assign tmr_cond[T_SC]   = (in_normal || (state_reg == CPF_OVERCHARGE)) &&
		sync2_reg[CMP_SC];
	assign tmr_cond[T_COC]  = in_normal && coc_en_reg && sync2_reg[CMP_COC];

	for (genvar i = 0; i < NUM_TMR; i++)
	begin : g_tmr
		cpf_delay_timer #(
			.CYCLES (TMR_CYC[i])
		) u_timer (
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.cond_i    (tmr_cond[i]),
			.expired_o (tmr_exp[i])
		);
	end

	// ------------------------------------------------------------------
	// Protection state machine
	// ------------------------------------------------------------------
	// Short circuit outranks slower faults so the fastest shutdown always wins.
	always_comb
	begin
		state_next  = state_reg;
		bias_next   = bias_reg;
		coc_en_next = coc_en_reg;
		case (state_reg)
			CPF_NORMAL:
			begin
				if (tmr_exp[T_SC])
					state_next = CPF_SHORT_CIRCUIT;
				else if (tmr_exp[T_DOC])
					state_next = CPF_DISCH_OVERCURRENT;
				else if (tmr_exp[T_UV])
				begin
					state_next  = CPF_OVERDISCHARGE;
					bias_next   = 1'b0;
					coc_en_next = 1'b0;
				end
				else if (tmr_exp[T_OV])
					state_next = CPF_OVERCHARGE;
				else if (tmr_exp[T_COC])
					state_next = CPF_CHG_OVERCURRENT;
			end
			CPF_OVERCHARGE:
			begin
				if (tmr_exp[T_SC])
					state_next = CPF_OC_SHORT;
				else if (tmr_exp[T_OVR] && !sync2_reg[CMP_CHGR] && sync2_reg[CMP_DOC])
					state_next = CPF_NORMAL;
			end
			CPF_OC_SHORT:
			begin
				if (!sync2_reg[CMP_LOAD] && !sync2_reg[CMP_SC])
					state_next = CPF_OVERCHARGE;
			end
			CPF_OVERDISCHARGE:
			begin
				if (!bias_reg && sync2_reg[CMP_CHGR])
					bias_next = 1'b1;
				if (tmr_exp[T_UVR])
					state_next = CPF_NORMAL;
			end
			CPF_DISCH_OVERCURRENT,
			CPF_SHORT_CIRCUIT:
			begin
				if (tmr_exp[T_DOCR] && !sync2_reg[CMP_LOAD])
					state_next = CPF_NORMAL;
			end
			CPF_CHG_OVERCURRENT:
			begin
				if (!sync2_reg[CMP_CHGR])
					state_next = CPF_NORMAL;
			end
			default:
			begin
				state_next = CPF_NORMAL;
				bias_next  = 1'b1;
			end
		endcase
		if (bias_reg && sync2_reg[CMP_UVR])
			coc_en_next = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg  <= CPF_NORMAL;
			bias_reg   <= 1'b1;
			coc_en_reg <= 1'b1;
		end
		else
		begin
			state_reg  <= state_next;
			bias_reg   <= bias_next;
			coc_en_reg <= coc_en_next;
		end
	end

	// ------------------------------------------------------------------
	// Switch and sense-pin outputs
	// ------------------------------------------------------------------
	logic chg_next;
	logic dchg_next;
	logic pdn_next;
	logic pup_next;

	always_comb
	begin
		chg_next  = !charge_blocked(state_reg) && !sync2_reg[CMP_ZERO] &&
			!force_off_reg;
		dchg_next = !discharge_blocked(state_reg) && !force_off_reg;
		pdn_next  = (state_reg == CPF_DISCH_OVERCURRENT) ||
			(state_reg == CPF_SHORT_CIRCUIT) || (state_reg == CPF_OC_SHORT);
		pup_next  = (state_reg == CPF_OVERDISCHARGE) && !bias_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			charge_switch_o    <= 1'b0;
			discharge_switch_o <= 1'b0;
			sense_pulldown_o   <= 1'b0;
			sense_pullup_o     <= 1'b0;
			bias_enable_o      <= 1'b1;
		end
		else
		begin
			charge_switch_o    <= chg_next;
			discharge_switch_o <= dchg_next;
			sense_pulldown_o   <= pdn_next;
			sense_pullup_o     <= pup_next;
			bias_enable_o      <= bias_reg;
		end
	end

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	// The force bit is a software kill switch; it never alters the fault state.
	logic [31:0] rdata_next;
	logic [31:0] status_word;

	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[STAT_STATE_LSB +: 4] = state_reg;
		status_word[STAT_CHG_BIT]        = charge_switch_o;
		status_word[STAT_DCHG_BIT]       = discharge_switch_o;
		status_word[STAT_PDN_BIT]        = sense_pulldown_o;
		status_word[STAT_PUP_BIT]        = sense_pullup_o;
		status_word[STAT_BIAS_BIT]       = bias_reg;
		status_word[STAT_COCEN_BIT]      = coc_en_reg;
		force_off_next = force_off_reg;
		if (reg_write_i && (reg_addr_i == CTRL_OFFSET))
			force_off_next = reg_wdata_i[CTRL_FORCE_BIT];
		rdata_next = 32'h0000_0000;
		if (reg_read_i)
		begin
			case (reg_addr_i)
				CTRL_OFFSET:   rdata_next = {31'h0000_0000, force_off_reg};
				STATUS_OFFSET: rdata_next = status_word;
				default:       rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			force_off_reg <= CTRL_RESET[CTRL_FORCE_BIT];
			reg_rdata_o   <= 32'h0000_0000;
		end
		else
		begin
			force_off_reg <= force_off_next;
			reg_rdata_o   <= rdata_next;
		end
	end

endmodule
`default_nettype wire

// ### tb/cpf_asserts.sv
// Pin-level checks of the cell protection block, bound into every instance.
// Assumes one clock, synchronous active-high reset and the instance's own counts.
`timescale 1ns/10ps
`default_nettype none
module cpf_asserts
	import cpf_pkg::*;
#(
	parameter int unsigned OV_CYC  = OV_CYCLES,
	parameter int unsigned UV_CYC  = UV_CYCLES,
	parameter int unsigned DOC_CYC = DOC_CYCLES,
	parameter int unsigned SC_CYC  = SC_CYCLES
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic overcharge_det_i,
	input wire logic overdischarge_det_i,
	input wire logic discharge_overcurrent_det_i,
	input wire logic short_circuit_det_i,
	input wire logic below_zero_volt_inhibit_i,
	input wire logic charge_switch_o,
	input wire logic discharge_switch_o,
	input wire logic sense_pulldown_o,
	input wire logic sense_pullup_o,
	input wire logic bias_enable_o
);
	// ------------------------------------------------------------------
	// Run lengths
	// ------------------------------------------------------------------
	// Two sync flops, the timer and two register stages lie between a pin and a
	// switch, so each check allows its count plus six cycles.
	int unsigned ov_run, uv_run, doc_run, sc_run;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ov_run  <= 32'h0;
			uv_run  <= 32'h0;
			doc_run <= 32'h0;
			sc_run  <= 32'h0;
		end
		else
		begin
			ov_run  <= overcharge_det_i ? ov_run + 32'h1 : 32'h0;
			uv_run  <= overdischarge_det_i ? uv_run + 32'h1 : 32'h0;
			doc_run <= (discharge_overcurrent_det_i && charge_switch_o) ? doc_run + 32'h1 : 32'h0;
			sc_run  <= short_circuit_det_i ? sc_run + 32'h1 : 32'h0;
		end
	end
	a_sc_trip: assert property (@(posedge clk_i) disable iff (rst_i)
		sc_run >= SC_CYC + 6 |-> !discharge_switch_o)
		else $error("discharge switch on after a held short circuit");
	a_doc_trip: assert property (@(posedge clk_i) disable iff (rst_i)
		doc_run >= DOC_CYC + 6 |-> !discharge_switch_o)
		else $error("discharge switch on after a held over-current");
	a_uv_trip: assert property (@(posedge clk_i) disable iff (rst_i)
		uv_run >= UV_CYC + 6 |-> !discharge_switch_o)
		else $error("discharge switch on after a held over-discharge");
	a_ov_trip: assert property (@(posedge clk_i) disable iff (rst_i)
		ov_run >= OV_CYC + 6 |-> !charge_switch_o)
		else $error("charge switch on after a held over-charge");
	a_zero_block: assert property (@(posedge clk_i) disable iff (rst_i)
		below_zero_volt_inhibit_i [*6] |-> !charge_switch_o)
		else $error("charge switch on below the zero-volt level");
	a_pulldown_cut: assert property (@(posedge clk_i) disable iff (rst_i)
		sense_pulldown_o |-> !discharge_switch_o)
		else $error("sense pull-down active with discharge switch on");
	a_pulls_apart: assert property (@(posedge clk_i) disable iff (rst_i)
		!(sense_pulldown_o && sense_pullup_o))
		else $error("sense pull-up and pull-down both active");
	a_standby_entry: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(bias_enable_o) |-> !discharge_switch_o && sense_pullup_o)
		else $error("bias shut off outside over-discharge stand-by");
endmodule
bind cell_protection_fsm cpf_asserts #(.OV_CYC(OV_CYC), .UV_CYC(UV_CYC), .DOC_CYC(DOC_CYC),
	.SC_CYC(SC_CYC)) i_cpf_asserts (.clk_i(clk_i), .rst_i(rst_i),
	.overcharge_det_i(overcharge_det_i), .overdischarge_det_i(overdischarge_det_i),
	.discharge_overcurrent_det_i(discharge_overcurrent_det_i),
	.short_circuit_det_i(short_circuit_det_i),
	.below_zero_volt_inhibit_i(below_zero_volt_inhibit_i), .charge_switch_o(charge_switch_o),
	.discharge_switch_o(discharge_switch_o), .sense_pulldown_o(sense_pulldown_o),
	.sense_pullup_o(sense_pullup_o), .bias_enable_o(bias_enable_o));
`default_nettype wire

// ### tb/cpf_cell_model.sv
// Behavioural cell, charger and load: turns millivolts and milliamps into comparator levels.
// Assumes the bench sets cell voltage, pin current and charger and load presence.
`timescale 1ns/10ps
`default_nettype none
module cpf_cell_model
	import cpf_pkg::*;
#(
	parameter int OV_MV   = 4285,
	parameter int OVR_MV  = 4085,
	parameter int UV_MV   = 2200,
	parameter int UVR_MV  = 2200,
	parameter int DOC_MA  = 6300,
	parameter int SC_MA   = 21000,
	parameter int COC_MA  = -4000,
	parameter int REL_MA  = 1000,
	parameter int ZERO_MV = 900
)
(
	input  wire logic signed [31:0]    cell_mv_i,
	input  wire logic signed [31:0]    sense_ma_i,
	input  wire logic                  charger_i,
	input  wire logic                  load_i,
	output logic        [NUM_CMP-1:0]  cmp_o
);
	logic signed [31:0] pin_ma;
	// With neither charger nor load attached no current flows through the sense pin.
	assign pin_ma = (charger_i || load_i) ? sense_ma_i : 32'sh0;
	always_comb
	begin
		cmp_o           = '0;
		cmp_o[CMP_OV]   = cell_mv_i >= OV_MV;
		cmp_o[CMP_OVR]  = cell_mv_i < OVR_MV;
		cmp_o[CMP_UV]   = cell_mv_i < UV_MV;
		cmp_o[CMP_UVR]  = cell_mv_i > UVR_MV;
		cmp_o[CMP_DOC]  = pin_ma >= DOC_MA;
		cmp_o[CMP_SC]   = pin_ma >= SC_MA;
		cmp_o[CMP_REL]  = pin_ma <= REL_MA && pin_ma >= -REL_MA;
		cmp_o[CMP_COC]  = pin_ma <= COC_MA;
		cmp_o[CMP_CHGR] = charger_i;
		cmp_o[CMP_LOAD] = load_i;
		cmp_o[CMP_ZERO] = cell_mv_i < ZERO_MV;
	end
endmodule
`default_nettype wire

// ### tb/test_cell_protection_fsm.sv
// Self-checking bench: walks the protection modes through the cell model and the register port.
// Assumes short delay counts; status is polled to see each mode settle.
`timescale 1ns/10ps
`default_nettype none
module test_cell_protection_fsm
	import cpf_pkg::*;
;
	logic               clk = 1'b0, rst = 1'b1, charger = 1'b0, load = 1'b1;
	logic               wr_s = 1'b0, rd_s = 1'b0, chg, dchg, pd, pu, bias;
	logic signed [31:0] cell_mv = 3700, sense_ma = 0;
	logic        [7:0]  addr = 8'h00;
	logic        [31:0] wdata = 32'h0, rdata, d;
	logic [NUM_CMP-1:0] cmp;
	int                 n_mismatch = 0, checked = 0, cyc = 0, i;

	// Short counts keep every delay within a few dozen cycles of simulation.
	localparam int unsigned TB_OV_CYC   = 10;
	localparam int unsigned TB_OVR_CYC  = 6;
	localparam int unsigned TB_UV_CYC   = 5;
	localparam int unsigned TB_UVR_CYC  = 5;
	localparam int unsigned TB_DOC_CYC  = 8;
	localparam int unsigned TB_DOCR_CYC = 4;
	localparam int unsigned TB_SC_CYC   = 3;
	localparam int unsigned TB_COC_CYC  = 4;

	initial forever #2 clk = ~clk;

	cell_protection_fsm #(.OV_CYC(TB_OV_CYC), .OVR_CYC(TB_OVR_CYC), .UV_CYC(TB_UV_CYC),
		.UVR_CYC(TB_UVR_CYC), .DOC_CYC(TB_DOC_CYC), .DOCR_CYC(TB_DOCR_CYC),
		.SC_CYC(TB_SC_CYC), .COC_CYC(TB_COC_CYC)) i_cell_protection_fsm (.clk_i(clk), .rst_i(rst),
		.overcharge_det_i(cmp[CMP_OV]), .below_overcharge_release_i(cmp[CMP_OVR]),
		.overdischarge_det_i(cmp[CMP_UV]), .above_overdischarge_release_i(cmp[CMP_UVR]),
		.discharge_overcurrent_det_i(cmp[CMP_DOC]), .short_circuit_det_i(cmp[CMP_SC]),
		.sense_release_i(cmp[CMP_REL]), .charge_overcurrent_det_i(cmp[CMP_COC]),
		.charger_present_i(cmp[CMP_CHGR]), .load_present_i(cmp[CMP_LOAD]),
		.below_zero_volt_inhibit_i(cmp[CMP_ZERO]), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_write_i(wr_s), .reg_read_i(rd_s), .reg_rdata_o(rdata), .charge_switch_o(chg),
		.discharge_switch_o(dchg), .sense_pulldown_o(pd), .sense_pullup_o(pu),
		.bias_enable_o(bias));
	cpf_cell_model i_cpf_cell_model (.cell_mv_i(cell_mv), .sense_ma_i(sense_ma),
		.charger_i(charger), .load_i(load), .cmp_o(cmp));

	// ------------------------------------------------------------------
	// Access and check tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// A spare cycle after the strobe keeps two writes from touching it in one step.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(posedge clk);
		v = rdata;
	endtask
	task automatic put(input int mv, input int ma, input logic ch, input logic ld);
		cell_mv <= mv;
		sense_ma <= ma;
		charger <= ch;
		load <= ld;
	endtask
	// Polls until the mode settles, then checks the status bits and the pins under a mask.
	task automatic want(input cpf_state_type st, input logic [9:4] bits, input logic [9:4] m);
		logic [31:0] v;
		int          k;
		for (k = 0; k < 80; k++)
		begin
			rd(STATUS_OFFSET, v);
			if (v[3:0] === st)
				break;
		end
		idle(2);
		rd(STATUS_OFFSET, v);
		chk("status", {22'h0, v[9:4] & m, v[3:0]}, {22'h0, bits & m, st});
		chk("pins", {27'h0, {bias, pu, pd, dchg, chg} & m[8:4]}, {27'h0, bits[8:4] & m[8:4]});
	endtask
	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial
	begin
		idle(3);
		rst <= 1'b0;
		idle(1);
		want(CPF_NORMAL, 6'h33, 6'h3f);
		rd(CTRL_OFFSET, d);
		chk("ctrl", d, CTRL_RESET);
		rd(8'h08, d);
		chk("unmapped", d, 32'h0);
		wr(CTRL_OFFSET, 32'h1);
		idle(2);
		chk("forced", {30'h0, chg, dchg}, 32'h0);
		wr(CTRL_OFFSET, 32'h0);
		repeat (4)
		begin
			put(3700, 7000, 0, 1);
			idle(6);
			put(3700, 0, 0, 1);
			idle(4);
		end
		want(CPF_NORMAL, 6'h33, 6'h3f);
		put(3700, 25000, 0, 1);
		want(CPF_SHORT_CIRCUIT, 6'h35, 6'h3f);
		put(3700, 25000, 0, 0);
		want(CPF_NORMAL, 6'h33, 6'h3f);
		put(3700, 7000, 0, 1);
		want(CPF_DISCH_OVERCURRENT, 6'h35, 6'h3f);
		put(3700, 7000, 0, 0);
		want(CPF_NORMAL, 6'h33, 6'h3f);
		put(4300, 0, 1, 0);
		want(CPF_OVERCHARGE, 6'h32, 6'h3f);
		put(4300, 7000, 1, 1);
		idle(30);
		want(CPF_OVERCHARGE, 6'h32, 6'h3f);
		put(4300, 25000, 1, 1);
		want(CPF_OC_SHORT, 6'h34, 6'h3f);
		put(4300, 0, 1, 0);
		want(CPF_OVERCHARGE, 6'h32, 6'h3f);
		put(4300, 7000, 0, 1);
		idle(30);
		want(CPF_OVERCHARGE, 6'h32, 6'h3f);
		put(4000, 7000, 0, 1);
		for (i = 0; i < 200 && chg !== 1'b1; i++)
			@(posedge clk);
		chk("chg", {31'h0, chg}, 32'h1);
		put(3700, 0, 0, 0);
		want(CPF_NORMAL, 6'h33, 6'h3f);
		put(2000, 0, 0, 1);
		want(CPF_OVERDISCHARGE, 6'h09, 6'h3f);
		put(2200, -5000, 1, 0);
		idle(30);
		want(CPF_OVERDISCHARGE, 6'h11, 6'h3f);
		put(2400, 0, 1, 0);
		want(CPF_NORMAL, 6'h33, 6'h3f);
		put(3700, -5000, 1, 0);
		want(CPF_CHG_OVERCURRENT, 6'h32, 6'h3f);
		put(3700, -5000, 0, 0);
		want(CPF_NORMAL, 6'h33, 6'h3f);
		put(500, 0, 1, 0);
		idle(20);
		chk("chg", {31'h0, chg}, 32'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
